//--- core/rtc_consts.vh
// constants for the real-time clock serial port and alarm/interrupt block
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH
`define RTC_SLAVE_ADDR     7'h68
`define RTC_REG_CONTROL    4'hE
`define RTC_REG_STATUS     4'hF
`define RTC_CONTROL_RESET  8'h18
`define RTC_STATUS_RESET   8'h80
`define RTC_CTL_OSC_DIS    7
`define RTC_CTL_RS_HI      4
`define RTC_CTL_RS_LO      3
`define RTC_CTL_ROUTING    2
`define RTC_CTL_ALARM_TWO_IRQ_ENABLE       1
`define RTC_CTL_ALARM_ONE_IRQ_ENABLE       0
`define RTC_ST_OSF         7
`define RTC_ST_A2F         1
`define RTC_ST_A1F         0
`define RTC_CORE_MHZ       200
`define RTC_OSC_TIMEOUT_NS 61035
`define RTC_FIFO_DEPTH     32
`define RTC_FIFO_AW        5
`endif

//--- core/rtc_i2c_slave.v
// serial slave port, alarm flags, interrupt routing and square wave of the clock chip
`timescale 1ns/1ps
`include "rtc_consts.vh"

module rtc_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             core_clk,
	input  wire             rst,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            do_wr;
	wire            do_rd;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign do_wr     = in_valid & in_ready;
	assign do_rd     = out_valid & out_ready;

	always @(posedge core_clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (do_wr & ~do_rd) begin
				count <= count + 1'b1;
			end else if (do_rd & ~do_wr) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // rtc_fifo

module rtc_i2c_slave #(
	parameter OSC_TIMEOUT_CYC = `RTC_OSC_TIMEOUT_NS * `RTC_CORE_MHZ / 1000
) (
	input  wire       core_clk,
	input  wire       rst,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	input  wire       osc_in,
	input  wire       alarm_one_match,
	input  wire       alarm_two_match,
	output reg        irq_out_a_n,
	output reg        square_or_irq_b,
	output reg        time_buf_refresh,
	output reg  [3:0] reg_pointer,
	input  wire [7:0] time_rd_data,
	output wire       time_wr_valid,
	input  wire       time_wr_ready,
	output wire [3:0] time_wr_addr,
	output wire [7:0] time_wr_data
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_ADDR  = 3'h1;
	localparam ST_ACK_A = 3'h2;
	localparam ST_RX    = 3'h3;
	localparam ST_ACK_W = 3'h4;
	localparam ST_TX    = 3'h5;
	localparam ST_ACK_R = 3'h6;

	// two-flop synchronisers; the edge detectors compare the second stage with its delayed copy
	reg        scl_s1, scl_s2, scl_d;
	reg        sda_s1, sda_s2, sda_d;
	reg        osc_s1, osc_s2, osc_d;
	reg [2:0]  state;
	reg [3:0]  bit_cnt;
	reg [7:0]  shreg;
	reg [7:0]  tx_byte;
	reg        rw;
	reg        ptr_phase;
	reg        master_nack;
	reg [7:0]  control;
	reg [7:0]  status;
	reg [14:0] osc_div;
	reg [13:0] osc_idle;
	reg        osc_dead;
	reg        fifo_push;
	reg [11:0] fifo_word;
	reg [7:0]  rd_byte;
	wire       fifo_ready;
	wire       fifo_out_valid;
	wire       fifo_out_ready;
	wire [3:0] fifo_out_addr;
	wire [7:0] fifo_out_data;
	reg        wr_out_valid;
	reg [3:0]  wr_out_addr;
	reg [7:0]  wr_out_data;
	wire       scl_rise, scl_fall, start_cond, stop_cond;
	wire       osc_rise, sec_tick, osc_run;
	wire       wr_ctl, wr_st;
	wire       a1_act, a2_act, sq_wave;

	assign scl_rise   = scl_s2 & ~scl_d;
	assign scl_fall   = ~scl_s2 & scl_d;
	assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign stop_cond  = scl_s2 & scl_d & ~sda_d & sda_s2;
	assign osc_run    = ~control[`RTC_CTL_OSC_DIS];
	assign osc_rise   = osc_s2 & ~osc_d & osc_run;
	assign sec_tick   = osc_rise & (osc_div == 15'h7FFF);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d  <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d  <= 1'b1;
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			osc_d  <= 1'b0;
		end else begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_d  <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_d  <= sda_s2;
			osc_s1 <= osc_in;
			osc_s2 <= osc_s1;
			osc_d  <= osc_s2;
		end
	end

	// read mux: time registers come from outside, the last two live here
	always @* begin
		if (reg_pointer == `RTC_REG_CONTROL) begin
			rd_byte = control;
		end else if (reg_pointer == `RTC_REG_STATUS) begin
			rd_byte = status;
		end else begin
			rd_byte = time_rd_data;
		end
	end

	// oscillator divider and stop watchdog; a disabled oscillator counts as stopped
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			osc_div  <= 15'h0000;
			osc_idle <= 14'h0000;
			osc_dead <= 1'b0;
		end else begin
			if (osc_rise) begin
				osc_div  <= osc_div + 15'h0001;
				osc_idle <= 14'h0000;
				osc_dead <= 1'b0;
			end else if (!osc_run || osc_idle >= OSC_TIMEOUT_CYC[13:0]) begin
				osc_dead <= 1'b1;
			end else begin
				osc_idle <= osc_idle + 14'h0001;
			end
		end
	end

	// serial slave: bytes are sampled on rising clock, the data line moves on falling
	assign wr_ctl = (state == ST_RX) && scl_fall && (bit_cnt == 4'h8) && !ptr_phase
		&& (reg_pointer == `RTC_REG_CONTROL);
	assign wr_st  = (state == ST_RX) && scl_fall && (bit_cnt == 4'h8) && !ptr_phase
		&& (reg_pointer == `RTC_REG_STATUS);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state            <= ST_IDLE;
			bit_cnt          <= 4'h0;
			shreg            <= 8'h00;
			tx_byte          <= 8'h00;
			rw               <= 1'b0;
			ptr_phase        <= 1'b0;
			master_nack      <= 1'b1;
			reg_pointer      <= 4'h0;
			sda_out          <= 1'b0;
			sda_oe           <= 1'b0;
			time_buf_refresh <= 1'b0;
			fifo_push        <= 1'b0;
			fifo_word        <= 12'h000;
		end else begin
			time_buf_refresh <= 1'b0;
			fifo_push        <= 1'b0;
			if (start_cond) begin
				state            <= ST_ADDR;
				bit_cnt          <= 4'h0;
				sda_oe           <= 1'b0;
				time_buf_refresh <= 1'b1;
			end else if (stop_cond) begin
				state            <= ST_IDLE;
				sda_oe           <= 1'b0;
				time_buf_refresh <= 1'b1;
			end else if (scl_rise) begin
				if (state == ST_ADDR || state == ST_RX || state == ST_TX) begin
					shreg   <= {shreg[6:0], sda_s2};
					bit_cnt <= bit_cnt + 4'h1;
				end else if (state == ST_ACK_R) begin
					master_nack <= sda_s2;
				end
			end else if (scl_fall) begin
				case (state)
				ST_ADDR: begin
					if (bit_cnt == 4'h8) begin
						if (shreg[7:1] == `RTC_SLAVE_ADDR) begin
							rw     <= shreg[0];
							sda_oe <= 1'b1;
							state  <= ST_ACK_A;
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_ACK_A: begin
					bit_cnt <= 4'h0;
					if (rw) begin
						tx_byte <= rd_byte;
						sda_oe  <= ~rd_byte[7];
						state   <= ST_TX;
					end else begin
						sda_oe    <= 1'b0;
						ptr_phase <= 1'b1;
						state     <= ST_RX;
					end
				end
				ST_RX: begin
					if (bit_cnt == 4'h8) begin
						state <= ST_ACK_W;
						if (ptr_phase) begin
							reg_pointer <= shreg[3:0];
							ptr_phase   <= 1'b0;
							sda_oe      <= 1'b1;
						end else begin
							// a full write queue refuses the byte with a nack
							if (reg_pointer < `RTC_REG_CONTROL) begin
								fifo_push <= fifo_ready;
								fifo_word <= {reg_pointer, shreg};
								sda_oe    <= fifo_ready;
							end else begin
								sda_oe <= 1'b1;
							end
							reg_pointer <= reg_pointer + 4'h1;
							if (reg_pointer == `RTC_REG_STATUS) begin
								time_buf_refresh <= 1'b1;
							end
						end
					end
				end
				ST_ACK_W: begin
					sda_oe  <= 1'b0;
					bit_cnt <= 4'h0;
					state   <= ST_RX;
				end
				ST_TX: begin
					if (bit_cnt == 4'h8) begin
						sda_oe      <= 1'b0;
						reg_pointer <= reg_pointer + 4'h1;
						if (reg_pointer == `RTC_REG_STATUS) begin
							time_buf_refresh <= 1'b1;
						end
						state <= ST_ACK_R;
					end else begin
						sda_oe <= ~tx_byte[3'h7 - bit_cnt[2:0]];
					end
				end
				ST_ACK_R: begin
					bit_cnt <= 4'h0;
					if (!master_nack) begin
						tx_byte <= rd_byte;
						sda_oe  <= ~rd_byte[7];
						state   <= ST_TX;
					end else begin
						sda_oe <= 1'b0;
						state  <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// control and status registers; hardware set beats a write of zero
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			control <= `RTC_CONTROL_RESET;
			status  <= `RTC_STATUS_RESET;
		end else begin
			if (wr_ctl) begin
				control <= shreg & 8'h9F;
			end
			status[`RTC_ST_OSF] <= osc_dead | (status[`RTC_ST_OSF] & ~(wr_st & ~shreg[`RTC_ST_OSF]));
			status[`RTC_ST_A2F] <= (sec_tick & alarm_two_match)
				| (status[`RTC_ST_A2F] & ~(wr_st & ~shreg[`RTC_ST_A2F]));
			status[`RTC_ST_A1F] <= (sec_tick & alarm_one_match)
				| (status[`RTC_ST_A1F] & ~(wr_st & ~shreg[`RTC_ST_A1F]));
			status[6:2] <= 5'h00;
		end
	end

	assign a1_act  = status[`RTC_ST_A1F] & control[`RTC_CTL_ALARM_ONE_IRQ_ENABLE];
	assign a2_act  = status[`RTC_ST_A2F] & control[`RTC_CTL_ALARM_TWO_IRQ_ENABLE];
	assign sq_wave = control[`RTC_CTL_RS_HI]
		? (control[`RTC_CTL_RS_LO] ? osc_s2 : osc_div[1])
		: (control[`RTC_CTL_RS_LO] ? osc_div[2] : osc_div[14]);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_out_a_n     <= 1'b1;
			square_or_irq_b <= 1'b1;
		end else if (control[`RTC_CTL_ROUTING]) begin
			irq_out_a_n     <= ~a1_act;
			square_or_irq_b <= ~a2_act;
		end else begin
			irq_out_a_n     <= ~(a1_act | a2_act);
			square_or_irq_b <= sq_wave;
		end
	end

	rtc_fifo #(
		.WIDTH(12),
		.DEPTH(`RTC_FIFO_DEPTH),
		.AW   (`RTC_FIFO_AW)
	) u_wr_fifo (
		.core_clk (core_clk),
		.rst      (rst),
		.in_valid (fifo_push),
		.in_ready (fifo_ready),
		.in_data  (fifo_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data ({fifo_out_addr, fifo_out_data})
	);

	// one-entry output stage keeps the write port on flops; it refills the cycle it empties
	assign fifo_out_ready = !wr_out_valid || time_wr_ready;
	assign time_wr_valid  = wr_out_valid;
	assign time_wr_addr   = wr_out_addr;
	assign time_wr_data   = wr_out_data;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_out_valid <= 1'b0;
			wr_out_addr  <= 4'h0;
			wr_out_data  <= 8'h00;
		end else if (fifo_out_ready) begin
			wr_out_valid <= fifo_out_valid;
			if (fifo_out_valid) begin
				wr_out_addr <= fifo_out_addr;
				wr_out_data <= fifo_out_data;
			end
		end
	end
endmodule // rtc_i2c_slave

//--- bench/rtc_i2c_slave_monitor.sv
// assertion checker on the serial slave block ports
`timescale 1ns/1ps
module rtc_i2c_slave_monitor (
	input wire       core_clk,
	input wire       rst,
	input wire       scl_in,
	input wire       sda_out,
	input wire       sda_oe,
	input wire       irq_out_a_n,
	input wire       time_buf_refresh,
	input wire [3:0] reg_pointer,
	input wire       time_wr_valid,
	input wire       time_wr_ready,
	input wire [3:0] time_wr_addr,
	input wire [7:0] time_wr_data
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	chk_ack_low: assert property (sda_oe |-> !sda_out)
		else $error("data line driven high");
	chk_oe_clock_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data drive changed with clock high");
	chk_oe_high_hold: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
		else $error("data drive moved during clock high");
	chk_reset_idle: assert property (disable iff (1'b0) rst |->
		!sda_oe && irq_out_a_n && reg_pointer == 4'h0 && !time_wr_valid)
		else $error("outputs not idle in reset");
	chk_refresh_pulse: assert property (time_buf_refresh |=> !time_buf_refresh)
		else $error("refresh longer than one cycle");
	// a missed refresh on roll-over would hand stale time to the next read
	chk_wrap_refresh: assert property ($past(reg_pointer) == 4'hF && reg_pointer == 4'h0 |->
		(time_buf_refresh || $past(time_buf_refresh) || $past(time_buf_refresh, 2)) or (##[1:2] time_buf_refresh))
		else $error("pointer wrap without refresh");
	chk_fifo_hold: assert property (time_wr_valid && !time_wr_ready |=>
		time_wr_valid && $stable(time_wr_addr) && $stable(time_wr_data))
		else $error("write entry changed while stalled");
	chk_fifo_range: assert property (time_wr_valid |-> time_wr_addr < 4'hE)
		else $error("local register sent to time side");
endmodule // rtc_i2c_slave_monitor

bind rtc_i2c_slave rtc_i2c_slave_monitor u_mon (.core_clk(core_clk), .rst(rst), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .irq_out_a_n(irq_out_a_n), .time_buf_refresh(time_buf_refresh),
	.reg_pointer(reg_pointer), .time_wr_valid(time_wr_valid), .time_wr_ready(time_wr_ready),
	.time_wr_addr(time_wr_addr), .time_wr_data(time_wr_data));

//--- bench/rtc_bus_master.sv
// bus master model: makes the clock, start, stop and bytes
`timescale 1ns/1ps
module rtc_bus_master #(
	parameter Q = 6
) (
	input wire core_clk,
	input wire sda,
	output reg scl,
	output reg sda_lo
);
	initial begin
		scl = 1'b1;
		sda_lo = 1'b0;
	end
	task w(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// waits of Q, Q, Q and Q+1 cycles give a 125 ns bus period, well past the rated rate
	task step(input logic s, input logic c);
		w(Q);
		sda_lo <= s;
		w(Q);
		scl <= c;
	endtask
	// works from idle and as a repeated start from a low clock
	task start();
		step(1'b0, 1'b1);
		step(1'b1, 1'b0);
	endtask
	task stop();
		step(1'b1, 1'b1);
		step(1'b0, 1'b1);
	endtask
	// data moves only while the clock is low
	task bit1(input logic b, output logic r);
		step(!b, 1'b1);
		w(Q);
		r = sda;
		w(Q + 1);
		scl <= 1'b0;
	endtask
	// msb first, ninth clock for the acknowledge
	task tx(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit1(d[i], r);
		bit1(1'b1, r);
		ack = !r;
	endtask
	// last byte left unacknowledged so the slave lets go
	task rx(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit1(1'b1, d[i]);
		bit1(!ack, r);
	endtask
endmodule // rtc_bus_master

//--- bench/rtc_i2c_slave_bench.sv
// bench for the serial slave port, status flags and square wave
`timescale 1ns/1ps
module rtc_i2c_slave_bench;
	logic       core_clk;
	logic       rst;
	logic       osc_in;
	logic [4:0] osc_cnt = 5'h00;
	logic       a1m;
	logic       a2m;
	logic       tw_ready;
	logic       ack;
	logic [7:0] b;
	wire        scl;
	wire        m_lo;
	wire        sda_out;
	wire        sda_oe;
	wire        sda;
	wire        irq_a;
	wire        sq_b;
	wire [3:0]  ptr;
	wire        wv;
	wire [3:0]  wa;
	wire [7:0]  wd;
	int         error_cnt = 0;
	int         cmp_count = 0;
	int         cyc = 0;
	// open-drain data line with pull-up
	assign sda = !((sda_oe && !sda_out) || m_lo);
	rtc_bus_master m (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_lo(m_lo));
	// short halt timeout, a few oscillator periods
	rtc_i2c_slave #(.OSC_TIMEOUT_CYC(100)) dut (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .osc_in(osc_in), .alarm_one_match(a1m), .alarm_two_match(a2m),
		.irq_out_a_n(irq_a), .square_or_irq_b(sq_b), .time_buf_refresh(), .reg_pointer(ptr),
		.time_rd_data({4'hA, ptr}), .time_wr_valid(wv), .time_wr_ready(tw_ready), .time_wr_addr(wa),
		.time_wr_data(wd));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = !core_clk;
	end
	// oscillator pin: 12 cycles high, 13 low, a 125 ns period driven on the clock edge
	always @(posedge core_clk) begin
		osc_cnt <= (osc_cnt == 5'h18) ? 5'h00 : osc_cnt + 5'h01;
		osc_in  <= (osc_cnt < 5'h0C);
	end
	task complete_run();
		$display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin // the run needs about 12000 cycles
			error_cnt++;
			complete_run();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task send(input logic [7:0] d, input logic exp_ack);
		m.tx(d, ack);
		chk(ack, exp_ack);
	endtask
	task wr(input logic [7:0] p, input logic [15:0] d, input int n);
		m.start();
		send(8'hD0, 1'b1);
		send(p, 1'b1);
		for (int i = 0; i < n; i++) send(d[15 - 8 * i -: 8], 1'b1);
		m.stop();
	endtask
	task rdc(input logic [7:0] x0, input logic [7:0] x1);
		m.start();
		send(8'hD1, 1'b1);
		m.rx(1'b1, b);
		chk(b, x0);
		m.rx(1'b0, b);
		chk(b, x1);
		m.stop();
	endtask
	task rd(input logic [7:0] p, input logic [7:0] x0, input logic [7:0] x1);
		m.start();
		send(8'hD0, 1'b1);
		send(p, 1'b1);
		rdc(x0, x1);
	endtask
	// counts output edges over 2000 cycles; two edges of slack for phase
	task sq(input int x);
		int n;
		logic p;
		n = 0;
		p = sq_b;
		repeat (2000) begin
			@(posedge core_clk);
			#1;
			if (sq_b !== p) n++;
			p = sq_b;
		end
		chk(8'((n > x - 3 && n < x + 3) ? x : n), 8'(x));
	endtask
	initial begin
		rst = 1'b1;
		a1m = 1'b0;
		a2m = 1'b0;
		tw_ready = 1'b0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		repeat (8) @(posedge core_clk);
		rd(8'h0E, 8'h18, 8'h80);
		sq(160);
		wr(8'h0F, 16'h7F5A, 2);
		chk(wv, 1'b1);
		chk(wa, 8'h00);
		chk(wd, 8'h5A);
		@(posedge core_clk);
		tw_ready <= 1'b1;
		@(posedge core_clk);
		tw_ready <= 1'b0;
		#1;
		chk(wv, 1'b0);
		wr(8'h0E, 16'h0800, 1);
		sq(20);
		rdc(8'h00, 8'hA0);
		// no once-a-second tick falls inside the run, so matches raise no flag
		a1m <= 1'b1;
		a2m <= 1'b1;
		wr(8'h0E, 16'h0400, 1);
		sq(0);
		chk(sq_b, 1'b1);
		chk(irq_a, 1'b1);
		// stopping the oscillator must raise the halt flag; ones written earlier set nothing
		wr(8'h0E, 16'h8400, 1);
		rdc(8'h80, 8'hA0);
		m.start();
		send(8'hA0, 1'b0);
		m.stop();
		complete_run();
	end
endmodule // rtc_i2c_slave_bench
